// File: sim/sda_attenuator_properties.sv
`timescale 1ns/1ps
module sda_attenuator_properties
	import sda_pkg::*;
(
	input wire logic                       mclk,
	input wire logic                       reset_n,
	input wire logic                       hsel,
	input wire logic [ADDR_W-1:0]          haddr,
	input wire logic [1:0]                 htrans,
	input wire logic                       hwrite,
	input wire logic [2:0]                 hsize,
	input wire logic [31:0]                hwdata,
	input wire logic                       hready,
	input wire logic [31:0]                hrdata,
	input wire logic                       hreadyout,
	input wire logic                       hresp,
	input wire logic [1:0]                 rate_family,
	input wire logic                       sample_strobe,
	input wire logic signed [SAMPLE_W-1:0] left_in,
	input wire logic signed [SAMPLE_W-1:0] right_in,
	input wire logic signed [SAMPLE_W-1:0] left_out,
	input wire logic signed [SAMPLE_W-1:0] right_out,
	input wire logic                       bitstream_gain_select
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);
	logic rd;
	logic wr_mode;
	assign rd = hsel && hready && htrans == HTRANS_NONSEQ && !hwrite;
	assign wr_mode = hsel && hready && htrans == HTRANS_NONSEQ && hwrite && haddr == 12'h020;
	property p_okay;
		hreadyout && !hresp;
	endproperty
	a_okay: assert property (p_okay) else $error("bus answer not ready and okay");
	property p_hold;
		!$past(sample_strobe) |-> $stable(left_out) && $stable(right_out);
	endproperty
	a_hold: assert property (p_hold) else $error("output moved without a sample");
	property p_zero;
		sample_strobe && left_in == '0 |=> left_out == '0;
	endproperty
	a_zero: assert property (p_zero) else $error("silent input gave sound");
	property p_gain;
		$changed(bitstream_gain_select) |-> $past(wr_mode) || $past(wr_mode, 2) || $past(wr_mode, 3);
	endproperty
	a_gain: assert property (p_gain) else $error("gain select moved without a write");
	property p_idle;
		!$past(rd) |-> hrdata == 32'h0;
	endproperty
	a_idle: assert property (p_idle) else $error("read data outside a data phase");
	property p_upd;
		$past(rd && haddr < 12'h010) |-> hrdata[31:5] == 27'h0;
	endproperty
	a_upd: assert property (p_upd) else $error("update bit read back");
	property p_lmag;
		sample_strobe && !left_in[SAMPLE_W-1] |=> !left_out[SAMPLE_W-1] && left_out <= $past(left_in);
	endproperty
	a_lmag: assert property (p_lmag) else $error("left gained level");
	property p_rmag;
		sample_strobe && !right_in[SAMPLE_W-1] |=> right_out <= $past(right_in) && !right_out[SAMPLE_W-1];
	endproperty
	a_rmag: assert property (p_rmag) else $error("right gained level");
endmodule
bind sda_attenuator sda_attenuator_properties chk_u (.mclk, .reset_n, .hsel, .haddr, .htrans,
	.hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .rate_family, .sample_strobe,
	.left_in, .right_in, .left_out, .right_out, .bitstream_gain_select);

// File: sim/stereo_digital_attenuator_tb.sv
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin errors++; $display("Error at %0t: got %h expected %h", $time, a, e); end end
module stereo_digital_attenuator_tb;
	import sda_pkg::*;
	logic mclk = 0, reset_n = 0, hsel = 0, hwrite = 0, strobe = 0, hready, hresp, gain;
	logic [11:0] haddr = '0;
	logic [1:0] htrans = '0, rate = '0;
	logic [2:0] hsize = HSIZE_WORD;
	logic [31:0] hwdata = '0, hrdata, q;
	logic signed [SAMPLE_W-1:0] lin = '0, rin = '0, lout, rout;
	logic [11:0] regs [7] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010, 12'h020, 12'h030};
	int errors = 0, total_checks = 0, cycles = 0;
	sda_attenuator dut_u (.mclk(mclk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
		.hrdata(hrdata), .hreadyout(hready), .hresp(hresp), .rate_family(rate),
		.sample_strobe(strobe), .left_in(lin), .right_in(rin), .left_out(lout),
		.right_out(rout), .bitstream_gain_select(gain));
	always #5 mclk = ~mclk;
	task automatic conclude();
		$display("Checks %0d, mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 3000) begin
			errors++;
			conclude();
		end
	end
	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= HTRANS_NONSEQ;
		do @(posedge mclk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge mclk); while (hready !== 1'b1);
		q = hrdata;
	endtask
	task automatic samp();
		strobe <= 1'b1;
		lin <= 24'sh100000;
		rin <= 24'sh100000;
		@(posedge mclk);
		strobe <= 1'b0;
		repeat (3) @(posedge mclk);
	endtask
	task automatic st(input logic [9:0] l, r);
		bus(1'b0, 12'h024, 32'h0);
		`CHK(q[9:0], l)
		`CHK(q[19:10], r)
	endtask
	initial begin
		repeat (4) @(posedge mclk);
		reset_n <= 1'b1;
		@(posedge mclk);
		foreach (regs[i]) begin
			bus(1'b0, regs[i], 32'h0);
			`CHK(q, 32'h0)
		end
		st(10'h000, 10'h000);
		$display("Test 1 done");
		bus(1'b1, 12'h000, 32'h1F);
		bus(1'b1, 12'h00C, 32'h1F);
		bus(1'b0, 12'h000, 32'h0);
		`CHK(q, 32'h1F)
		st(10'h000, 10'h000);
		samp();
		`CHK(lout, 24'sh100000)
		$display("Test 2 done");
		bus(1'b1, 12'h004, 32'h3F);
		bus(1'b0, 12'h004, 32'h0);
		`CHK(q, 32'h1F)
		samp();
		st(10'h3FF, 10'h3E0);
		samp();
		`CHK(lout, 24'sh0)
		$display("Test 3 done");
		bus(1'b1, 12'h010, 32'h4);
		samp();
		samp();
		`CHK(rout, 24'sh0)
		bus(1'b1, 12'h010, 32'h0);
		bus(1'b0, 12'h00C, 32'h0);
		`CHK(q, 32'h1F)
		st(10'h3FF, 10'h3E0);
		$display("Test 4 done");
		bus(1'b1, 12'h000, 32'h0);
		bus(1'b1, 12'h004, 32'h0);
		bus(1'b1, 12'h00C, 32'h20);
		samp();
		st(10'h000, 10'h000);
		samp();
		`CHK(rout, 24'sh100000)
		$display("Test 5 done");
		bus(1'b1, 12'h010, 32'h2);
		samp();
		samp();
		`CHK(lout > 24'shCB000 && lout < 24'shCC000, 1'b1)
		bus(1'b1, 12'h010, 32'h0);
		samp();
		samp();
		`CHK(lout, 24'sh100000)
		$display("Test 6 done");
		rate <= RATE_48K;
		bus(1'b1, 12'h010, 32'h1);
		bus(1'b1, 12'h004, 32'h21);
		repeat (6) samp();
		bus(1'b0, 12'h024, 32'h0);
		`CHK(q[9:0] > 10'h000 && q[9:0] < 10'h020, 1'b1)
		repeat (130) samp();
		st(10'h020, 10'h000);
		$display("Test 7 done");
		bus(1'b1, 12'h020, 32'h40);
		bus(1'b0, 12'h020, 32'h0);
		`CHK(q, 32'h40)
		`CHK(gain, 1'b1)
		bus(1'b1, 12'h020, 32'h0);
		bus(1'b0, 12'h020, 32'h0);
		`CHK(gain, 1'b0)
		$display("Test 8 done");
		conclude();
	end
endmodule

// File: src/sda_attenuator.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Each channel sample is scaled by its active attenuation on the sample strobe.
// - Ten-bit code, low five bits 0.125dB in one register, high 4dB in another.
// - Code zero is 0dB, each step 0.125dB more, 3FF mutes.
// - All four attenuation registers are pre-latched; both channels update together.
// - Write to an attenuation register with bit 5 set loads all pre-latches into the targets, applied at the next sample when ramp is clear.
// - Write with bit 5 clear only stores the pre-latch.
// - The update bit is never stored in a register; it sets update_pending and loads the pre-latches into the targets.
// - Tracking bit makes right use left active attenuation from next sample.
// - Right stored values stay intact while tracking is on.
// - Ramp bit clear changes the level in a single step.
// - Ramp bit set moves gradually at the rate set by sample-rate family.
// - Anti-clipping bit adds a fixed 2dB cut, none when clear.
// - Gain select bit picks low or high gain on the bitstream path.
module sda_attenuator (
	input  wire logic                          mclk,
	input  wire logic                          reset_n,
	input  wire logic                          hsel,
	input  wire logic [sda_pkg::ADDR_W-1:0]    haddr,
	input  wire logic [1:0]                    htrans,
	input  wire logic                          hwrite,
	input  wire logic [2:0]                    hsize,
	input  wire logic [31:0]                   hwdata,
	input  wire logic                          hready,
	output logic      [31:0]                   hrdata,
	output logic                               hreadyout,
	output logic                               hresp,
	input  wire logic [1:0]                    rate_family,
	input  wire logic                          sample_strobe,
	input  wire logic signed [sda_pkg::SAMPLE_W-1:0] left_in,
	input  wire logic signed [sda_pkg::SAMPLE_W-1:0] right_in,
	output logic signed [sda_pkg::SAMPLE_W-1:0] left_out,
	output logic signed [sda_pkg::SAMPLE_W-1:0] right_out,
	output logic                               bitstream_gain_select
);
	import sda_pkg::*;

	// Gain for the low five code bits in Q16: bit i is a cut of 0.125dB times 2^i.
	// Products are widened before the shift so that no high bits are lost.
	function automatic logic [16:0] eighth_db_gain(input logic [4:0] k);
		logic [16:0] g;
		logic [16:0] step [HALF_W];
		step = '{17'd64600, 17'd63677, 17'd61870, 17'd58409, 17'd52057};
		g = 17'h10000;
		for (int i = 0; i < HALF_W; i++) begin
			if (k[i]) begin
				g = 17'((34'(g) * 34'(step[i])) >> 16);
			end
		end
		return g;
	endfunction

	// Scales a sample by a full ten-bit code; any extra codes are added by the caller.
	function automatic logic signed [SAMPLE_W-1:0] apply_code(
		input logic signed [SAMPLE_W-1:0] s,
		input logic [CODE_W-1:0]          code
	);
		logic signed [SAMPLE_W+17:0] p;
		logic [16:0]                 hi_gain;
		p = '0;
		hi_gain = 17'h10000;
		// Each 4dB step is a factor of 0.631, stored as 41351/65536.
		for (int i = 0; i < HALF_W; i++) begin
			if (code[HALF_W+i]) begin
				for (int j = 0; j < (1 << i); j++) begin
					hi_gain = 17'((34'(hi_gain) * 34'(17'd41351)) >> 16);
				end
			end
		end
		if (code == CODE_MUTE) begin
			return '0;
		end
		p = s * $signed({1'b0, eighth_db_gain(code[HALF_W-1:0])});
		p = (p >>> 16) * $signed({1'b0, hi_gain});
		return SAMPLE_W'(p >>> 16);
	endfunction

	logic [HALF_W-1:0] pre_left_low, pre_left_high, pre_right_low, pre_right_high;
	logic [HALF_W-1:0] next_pre_left_low, next_pre_left_high;
	logic [HALF_W-1:0] next_pre_right_low, next_pre_right_high;
	logic [CODE_W-1:0] target_left, target_right, next_target_left, next_target_right;
	logic [CODE_W-1:0] left_atten_code, right_atten_code;
	logic [CODE_W-1:0] next_left_atten_code, next_right_atten_code;
	logic              update_pending, next_update_pending;
	logic              volume_ramp_enable, anticlip_cut_enable, left_tracking_enable;
	logic              next_ramp, next_anticlip, next_track, next_gain;
	logic [3:0]        step_count, next_step_count;
	logic              wr_phase, next_wr_phase;
	logic [3:0]        addr_idx, next_addr_idx;
	logic [31:0]       next_hrdata;
	logic signed [SAMPLE_W-1:0] next_left_out, next_right_out;

	logic addr_ok;
	logic phase_go;
	assign phase_go = hsel && hready && htrans == HTRANS_NONSEQ;
	// Upper address bits must be zero so that the map does not alias.
	assign addr_ok  = haddr[1:0] == 2'b00 && haddr[ADDR_W-1:6] == '0 && hsize == HSIZE_WORD;

	function automatic logic [3:0] step_limit(input logic [1:0] fam);
		unique case (fam)
			RATE_44K: return STEP_SAMPLES_44K;
			RATE_48K: return STEP_SAMPLES_48K;
			default:  return STEP_SAMPLES_32K;
		endcase
	endfunction

	function automatic logic [CODE_W-1:0] step_toward(
		input logic [CODE_W-1:0] cur,
		input logic [CODE_W-1:0] tgt
	);
		if (cur < tgt) begin
			return cur + 10'h001;
		end else if (cur > tgt) begin
			return cur - 10'h001;
		end
		return cur;
	endfunction

	// Register file and bus phases.
	always_comb begin
		logic [HALF_W-1:0] wv;
		logic              upd;
		wv = hwdata[HALF_W-1:0];
		upd = 1'b0;
		next_pre_left_low   = pre_left_low;
		next_pre_left_high  = pre_left_high;
		next_pre_right_low  = pre_right_low;
		next_pre_right_high = pre_right_high;
		next_ramp     = volume_ramp_enable;
		next_anticlip = anticlip_cut_enable;
		next_track    = left_tracking_enable;
		next_gain     = bitstream_gain_select;
		next_wr_phase = phase_go && hwrite && addr_ok;
		next_addr_idx = haddr[5:2];
		next_hrdata   = '0;
		if (wr_phase) begin
			unique case (addr_idx)
				IDX_LEFT_LOW:   next_pre_left_low   = wv;
				IDX_LEFT_HIGH:  next_pre_left_high  = wv;
				IDX_RIGHT_LOW:  next_pre_right_low  = wv;
				IDX_RIGHT_HIGH: next_pre_right_high = wv;
				IDX_VOLUME: begin
					next_ramp     = hwdata[BIT_RAMP];
					next_anticlip = hwdata[BIT_ANTICLIP];
					next_track    = hwdata[BIT_TRACK];
				end
				IDX_MODE_TWO:   next_gain = hwdata[BIT_GAIN];
				default: ;
			endcase
			// The update bit is consumed here; of the flops only update_pending takes it.
			upd = addr_idx <= IDX_RIGHT_HIGH && hwdata[BIT_UPDATE];
		end
		next_target_left  = target_left;
		next_target_right = target_right;
		next_update_pending = update_pending;
		if (upd) begin
			next_target_left  = {next_pre_left_high, next_pre_left_low};
			next_target_right = {next_pre_right_high, next_pre_right_low};
			next_update_pending = 1'b1;
		end
		// Read data is registered at the address edge so that it stands in the data phase.
		if (phase_go && !hwrite && addr_ok) begin
			unique case (haddr[5:2])
				IDX_LEFT_LOW:   next_hrdata = 32'(pre_left_low);
				IDX_LEFT_HIGH:  next_hrdata = 32'(pre_left_high);
				IDX_RIGHT_LOW:  next_hrdata = 32'(pre_right_low);
				IDX_RIGHT_HIGH: next_hrdata = 32'(pre_right_high);
				IDX_VOLUME: next_hrdata = 32'({left_tracking_enable, anticlip_cut_enable,
					volume_ramp_enable});
				IDX_MODE_TWO: next_hrdata = 32'({bitstream_gain_select, 6'h00});
				IDX_STATUS: next_hrdata = {12'h000, right_atten_code, left_atten_code};
				default: next_hrdata = '0;
			endcase
		end
		// Sample-boundary application of active codes.
		next_left_atten_code  = left_atten_code;
		next_right_atten_code = right_atten_code;
		next_step_count       = step_count;
		if (sample_strobe) begin
			if (!volume_ramp_enable) begin
				next_left_atten_code  = target_left;
				next_right_atten_code = target_right;
				next_step_count       = '0;
			end else if (step_count + 4'h1 >= step_limit(rate_family)) begin
				next_left_atten_code  = step_toward(left_atten_code, target_left);
				next_right_atten_code = step_toward(right_atten_code, target_right);
				next_step_count       = '0;
			end else begin
				next_step_count = step_count + 4'h1;
			end
			next_update_pending = upd;
		end
	end

	// Sample path: tracking picks the left code without touching right state.
	always_comb begin
		logic [CODE_W-1:0] rcode, lcode;
		lcode = left_atten_code;
		rcode = left_tracking_enable ? left_atten_code : right_atten_code;
		next_left_out  = left_out;
		next_right_out = right_out;
		if (sample_strobe) begin
			next_left_out  = apply_code(left_in, lcode);
			next_right_out = apply_code(right_in, rcode);
			if (anticlip_cut_enable) begin
				// Folded in as sixteen extra eighth-dB codes, saturating into mute.
				next_left_out  = apply_code(left_in, (lcode > CODE_MUTE - ANTICLIP_CODES)
					? CODE_MUTE : lcode + ANTICLIP_CODES);
				next_right_out = apply_code(right_in, (rcode > CODE_MUTE - ANTICLIP_CODES)
					? CODE_MUTE : rcode + ANTICLIP_CODES);
			end
		end
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			pre_left_low          <= HALF_RESET;
			pre_left_high         <= HALF_RESET;
			pre_right_low         <= HALF_RESET;
			pre_right_high        <= HALF_RESET;
			target_left           <= CODE_RESET;
			target_right          <= CODE_RESET;
			left_atten_code       <= CODE_RESET;
			right_atten_code      <= CODE_RESET;
			update_pending        <= 1'b0;
			volume_ramp_enable    <= 1'b0;
			anticlip_cut_enable   <= 1'b0;
			left_tracking_enable  <= 1'b0;
			bitstream_gain_select <= 1'b0;
			step_count            <= '0;
			wr_phase              <= 1'b0;
			addr_idx              <= '0;
			hrdata                <= '0;
			hreadyout             <= 1'b1;
			hresp                 <= 1'b0;
			left_out              <= '0;
			right_out             <= '0;
		end else begin
			pre_left_low          <= next_pre_left_low;
			pre_left_high         <= next_pre_left_high;
			pre_right_low         <= next_pre_right_low;
			pre_right_high        <= next_pre_right_high;
			target_left           <= next_target_left;
			target_right          <= next_target_right;
			left_atten_code       <= next_left_atten_code;
			right_atten_code      <= next_right_atten_code;
			update_pending        <= next_update_pending;
			volume_ramp_enable    <= next_ramp;
			anticlip_cut_enable   <= next_anticlip;
			left_tracking_enable  <= next_track;
			bitstream_gain_select <= next_gain;
			step_count            <= next_step_count;
			wr_phase              <= next_wr_phase;
			addr_idx              <= next_addr_idx;
			hrdata                <= next_hrdata;
			hreadyout             <= 1'b1;
			hresp                 <= 1'b0;
			left_out              <= next_left_out;
			right_out             <= next_right_out;
		end
	end
endmodule

// File: src/sda_pkg.sv
package sda_pkg;
	localparam int ADDR_W = 12;
	localparam int CODE_W = 10;
	localparam int HALF_W = 5;
	localparam int SAMPLE_W = 24;

	// Printed offsets 0..4 and 8 are not all multiples of four, so they are indices.
	localparam logic [3:0] IDX_LEFT_LOW   = 4'h0;
	localparam logic [3:0] IDX_LEFT_HIGH  = 4'h1;
	localparam logic [3:0] IDX_RIGHT_LOW  = 4'h2;
	localparam logic [3:0] IDX_RIGHT_HIGH = 4'h3;
	localparam logic [3:0] IDX_VOLUME     = 4'h4;
	localparam logic [3:0] IDX_MODE_TWO   = 4'h8;
	localparam logic [3:0] IDX_STATUS     = 4'h9;

	localparam int BIT_UPDATE    = 5;
	localparam int BIT_RAMP      = 0;
	localparam int BIT_ANTICLIP  = 1;
	localparam int BIT_TRACK     = 2;
	localparam int BIT_GAIN      = 6;

	localparam logic [CODE_W-1:0] CODE_MUTE  = 10'h3FF;
	localparam logic [CODE_W-1:0] CODE_RESET = 10'h000;
	localparam logic [HALF_W-1:0] HALF_RESET = 5'h00;

	// Two dB of cut is sixteen eighth-dB codes.
	localparam logic [CODE_W-1:0] ANTICLIP_CODES = 10'h010;

	localparam logic [1:0] RATE_32K = 2'h0;
	localparam logic [1:0] RATE_44K = 2'h1;
	localparam logic [1:0] RATE_48K = 2'h2;

	// Ramp time per eighth-dB step in microseconds: ms/dB times 125.
	localparam int RAMP_US_32K = 125;
	localparam int RAMP_US_44K = 91;
	localparam int RAMP_US_48K = 83;
	// Input samples per step at the base rate of each family, rounded to nearest.
	// Truncating would make the 48k family ramp a third too fast.
	localparam logic [3:0] STEP_SAMPLES_32K = 4'((RAMP_US_32K * 32 + 500) / 1000);
	localparam logic [3:0] STEP_SAMPLES_44K = 4'((RAMP_US_44K * 441 + 5000) / 10000);
	localparam logic [3:0] STEP_SAMPLES_48K = 4'((RAMP_US_48K * 48 + 500) / 1000);

	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD    = 3'h2;
endpackage
